// ### verilog/nio_pkg.sv
package nio_pkg;

  // Port geometry
  localparam int NIO_NIBBLE_W = 4;
  localparam int NIO_PORTS    = 4;

  // Control nibble fields
  localparam int NIO_SEL_LSB  = 0;
  localparam int NIO_SEL_MSB  = 1;
  localparam int NIO_OP_LSB   = 2;
  localparam int NIO_OP_MSB   = 3;

  // Operation codes
  localparam logic [1:0] NIO_OP_READ  = 2'h0;
  localparam logic [1:0] NIO_OP_WRITE = 2'h1;
  localparam logic [1:0] NIO_OP_OR    = 2'h2;
  localparam logic [1:0] NIO_OP_AND   = 2'h3;

  // Reset values
  localparam logic [3:0] NIO_LATCH_RST = 4'h0;
  localparam logic [1:0] NIO_SEL_RST   = 2'h0;

  // Synchroniser: strobe, select, host nibble, four peripheral nibbles
  localparam int NIO_SYNC_W   = 2 + NIO_NIBBLE_W * (1 + NIO_PORTS);

  // Transaction phase
  typedef enum logic {
    NIO_IDLE,
    NIO_ACTIVE
  } nio_phase_t;

endpackage

// ### verilog/nio_sync.sv
`timescale 1ns/1ps
module nio_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  // Asynchronous in, synchronised out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  // Both flop stages of every bit
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } nio_sync_t;

  nio_sync_t r;
  nio_sync_t next_r;

  // First stage feeds only the second
  always_comb begin
    next_r        = r;
    next_r.stage1 = async_i;
    next_r.stage2 = r.stage1;
  end

  // Both stages cleared in reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Output straight from the second stage
  assign sync_o = r.stage2;

endmodule

// ### verilog/nio_expander.sv
`timescale 1ns/1ps
module nio_expander (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // Host control
  input  wire logic       program_strobe_i,
  input  wire logic       chip_select_n_i,
  // Host nibble port
  input  wire logic [3:0] host_nibble_port_i,
  output logic      [3:0] host_nibble_port_o,
  output logic      [3:0] host_nibble_port_oe_o,
  // Peripheral port a
  input  wire logic [3:0] peripheral_port_a_i,
  output logic      [3:0] peripheral_port_a_o,
  output logic      [3:0] peripheral_port_a_oe_o,
  // Peripheral port b
  input  wire logic [3:0] peripheral_port_b_i,
  output logic      [3:0] peripheral_port_b_o,
  output logic      [3:0] peripheral_port_b_oe_o,
  // Peripheral port c
  input  wire logic [3:0] peripheral_port_c_i,
  output logic      [3:0] peripheral_port_c_o,
  output logic      [3:0] peripheral_port_c_oe_o,
  // Peripheral port d
  input  wire logic [3:0] peripheral_port_d_i,
  output logic      [3:0] peripheral_port_d_o,
  output logic      [3:0] peripheral_port_d_oe_o
);

  // Whole state of the block
  typedef struct packed {
    // Transfer phase and strobe edge tracking
    nio_pkg::nio_phase_t phase;
    logic                strobe_q;
    // Port and operation taken at the falling edge
    logic [1:0]          sel;
    logic [1:0]          op;
    // Output latches and drive enables, port a first
    logic [3:0][3:0]     latch;
    logic [3:0]          drive;
    // Read data path to the host port
    logic [3:0]          host_out;
    logic                host_oe;
  } nio_state_t;

  nio_state_t r;
  nio_state_t next_r;

  // Reset state: every pin released, latches cleared
  localparam nio_state_t NIO_STATE_RST = '{
    phase:    nio_pkg::NIO_IDLE,
    strobe_q: 1'b0,
    sel:      nio_pkg::NIO_SEL_RST,
    op:       nio_pkg::NIO_OP_READ,
    latch:    {nio_pkg::NIO_PORTS{nio_pkg::NIO_LATCH_RST}},
    drive:    4'h0,
    host_out: nio_pkg::NIO_LATCH_RST,
    host_oe:  1'b0
  };

  // Synchronised pin values
  logic [nio_pkg::NIO_SYNC_W-1:0] raw_in;
  logic [nio_pkg::NIO_SYNC_W-1:0] sync_in;
  logic                           strobe_s;
  logic                           cs_n_s;
  logic [3:0]                     host_s;
  logic [3:0][3:0]                periph_s;

  // Strobe edges seen on the system clock
  logic                           strobe_fall;
  logic                           strobe_rise;

  // Fields of the control nibble on the host port
  logic [1:0]                     cap_sel;
  logic [1:0]                     cap_op;

  // Combine the new nibble with the old latch per operation
  function automatic logic [3:0] nio_apply(input logic [1:0] op,
                                           input logic [3:0] old_val,
                                           input logic [3:0] new_val);
    logic [3:0] res;
    res = old_val;
    case (op)
      nio_pkg::NIO_OP_WRITE: res = new_val;
      nio_pkg::NIO_OP_OR:    res = old_val | new_val;
      nio_pkg::NIO_OP_AND:   res = old_val & new_val;
      default:               res = old_val;
    endcase
    return res;
  endfunction

  // Read is the only operation that leaves the latch alone
  function automatic logic nio_is_read(input logic [1:0] op);
    return op == nio_pkg::NIO_OP_READ;
  endfunction

  // Take a new control nibble in any phase
  function automatic nio_state_t nio_capture(input nio_state_t s,
                                             input logic [1:0] sel,
                                             input logic [1:0] op);
    nio_state_t res;
    res         = s;
    res.sel     = sel;
    res.op      = op;
    res.phase   = nio_pkg::NIO_ACTIVE;
    res.host_oe = nio_is_read(op);
    // Reads turn the port round and drive the host
    if (nio_is_read(op)) begin
      res.drive[sel] = 1'b0;
    end
    return res;
  endfunction

  // All pins from outside except clock and reset pass two flops first
  assign raw_in = {program_strobe_i, chip_select_n_i, host_nibble_port_i,
                   peripheral_port_d_i, peripheral_port_c_i,
                   peripheral_port_b_i, peripheral_port_a_i};

  // One synchroniser carries the whole bundle
  nio_sync #(
    .W (nio_pkg::NIO_SYNC_W)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   (raw_in),
    .sync_o    (sync_in)
  );

  // Unpack synchronised bundle
  assign strobe_s = sync_in[nio_pkg::NIO_SYNC_W-1];
  assign cs_n_s   = sync_in[nio_pkg::NIO_SYNC_W-2];
  assign host_s   = sync_in[nio_pkg::NIO_SYNC_W-3 -: nio_pkg::NIO_NIBBLE_W];

  // Peripheral nibbles, port a in the lowest bits
  genvar gi;
  generate
    for (gi = 0; gi < nio_pkg::NIO_PORTS; gi++) begin : g_periph
      assign periph_s[gi] = sync_in[gi*nio_pkg::NIO_NIBBLE_W +:
                                    nio_pkg::NIO_NIBBLE_W];
    end
  endgenerate

  // Strobe edges found on the system clock
  assign strobe_fall = r.strobe_q & ~strobe_s;
  assign strobe_rise = ~r.strobe_q & strobe_s;

  // Control nibble fields
  assign cap_sel = host_s[nio_pkg::NIO_SEL_MSB:nio_pkg::NIO_SEL_LSB];
  assign cap_op  = host_s[nio_pkg::NIO_OP_MSB:nio_pkg::NIO_OP_LSB];

  // Next-state logic
  always_comb begin
    next_r          = r;
    next_r.strobe_q = strobe_s;
    // Deselected: strobe edges change nothing
    if (!cs_n_s) begin
      case (r.phase)
        nio_pkg::NIO_IDLE: begin
          // Falling edge opens a transfer
          if (strobe_fall) begin
            next_r = nio_capture(next_r, cap_sel, cap_op);
          end
        end
        nio_pkg::NIO_ACTIVE: begin
          if (strobe_rise) begin
            // Rising edge closes the transfer
            next_r.phase   = nio_pkg::NIO_IDLE;
            next_r.host_oe = 1'b0;
            if (!nio_is_read(r.op)) begin
              next_r.latch[r.sel] = nio_apply(r.op, r.latch[r.sel],
                                              host_s);
              next_r.drive[r.sel] = 1'b1;
            end
          end else if (strobe_fall) begin
            // Lost rising edge: start over with the new nibble
            next_r = nio_capture(next_r, cap_sel, cap_op);
          end
        end
        default: begin
          // Unused phase code falls back to idle
          next_r.phase = nio_pkg::NIO_IDLE;
        end
      endcase
    end
    // Track the selected input while reading
    if (next_r.host_oe) begin
      next_r.host_out = periph_s[next_r.sel];
    end
  end

  // State register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= NIO_STATE_RST;
    end else begin
      r <= next_r;
    end
  end

  // Host port: read data plus its enable
  assign host_nibble_port_o     = r.host_out;
  assign host_nibble_port_oe_o  = {4{r.host_oe}};

  // Port a: latch plus drive enable
  assign peripheral_port_a_o    = r.latch[0];
  assign peripheral_port_a_oe_o = {4{r.drive[0]}};

  // Port b: latch plus drive enable
  assign peripheral_port_b_o    = r.latch[1];
  assign peripheral_port_b_oe_o = {4{r.drive[1]}};

  // Port c: latch plus drive enable
  assign peripheral_port_c_o    = r.latch[2];
  assign peripheral_port_c_oe_o = {4{r.drive[2]}};

  // Port d: latch plus drive enable
  assign peripheral_port_d_o    = r.latch[3];
  assign peripheral_port_d_oe_o = {4{r.drive[3]}};

endmodule

// ### tb/nio_chk_properties.sv
`timescale 1ns/1ps
module nio_chk (
  // Clock, reset and host side
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  input wire logic       program_strobe_i,
  input wire logic       chip_select_n_i,
  input wire logic [3:0] host_nibble_port_oe_o,
  // Peripheral port a
  input wire logic [3:0] peripheral_port_a_o,
  input wire logic [3:0] peripheral_port_a_oe_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Enables move as whole nibbles
  host_oe_a: assert property (host_nibble_port_oe_o inside {4'h0, 4'hF})
    else $error("host oe split");
  port_oe_a: assert property (peripheral_port_a_oe_o inside
    {4'h0, 4'hF}) else $error("port oe split");
  // Deselected device keeps the port still
  cs_hold_a: assert property (chip_select_n_i [*8] |->
    $stable(peripheral_port_a_o) && $stable(peripheral_port_a_oe_o))
    else $error("port moved while deselected");
  // Read drive starts inside the low strobe phase, ends after the rising strobe and comes with the port release
  rd_start_a: assert property ($rose(host_nibble_port_oe_o[0]) |->
    !program_strobe_i && !$past(program_strobe_i, 2))
    else $error("host drive early");
  rd_end_a: assert property ($rose(program_strobe_i) &&
    host_nibble_port_oe_o[0] |-> ##[2:5] !host_nibble_port_oe_o[0])
    else $error("host drive stuck");
  rd_tri_a: assert property ($fell(peripheral_port_a_oe_o[0]) |->
    ##[0:2] host_nibble_port_oe_o[0]) else $error("tristate without read");
  // Writes land after the rising strobe and drive the latch
  wr_drive_a: assert property ($rose(peripheral_port_a_oe_o[0]) |->
    program_strobe_i && $past(program_strobe_i, 2)) else $error("early drive");
  latch_en_a: assert property ($changed(peripheral_port_a_o) |->
    peripheral_port_a_oe_o[0]) else $error("latch moved undriven");
  // Main scenarios
  cover property ($rose(host_nibble_port_oe_o[0]));
  cover property ($rose(peripheral_port_a_oe_o[0]));
  cover property (chip_select_n_i [*8]);
endmodule
bind nio_expander nio_chk u_chk (.*);

// ### tb/nio_host.sv
`timescale 1ns/1ps
module nio_host (
  // Clock and host pins
  input  wire logic       sys_clk_i,
  input  wire logic [3:0] pin_i,
  output logic            strobe_o = 1'b1,
  output logic            cs_n_o   = 1'b1,
  output logic      [3:0] nib_o    = 4'h0
);
  // One strobe frame: four clocks low, four high
  task automatic xfer(input logic [3:0] ctl, input logic [3:0] dat,
                      input logic cs_n, output logic [3:0] rd);
    @(negedge sys_clk_i);
    cs_n_o   = cs_n;
    strobe_o = 1'b0;
    nib_o    = ctl;
    repeat (3) @(negedge sys_clk_i);
    // Read releases the pin: show the inverse meanwhile
    nib_o = (ctl[3:2] == 2'h0) ? ~ctl : dat;
    @(negedge sys_clk_i);
    rd       = pin_i;
    strobe_o = 1'b1;
    repeat (4) @(negedge sys_clk_i);
  endtask
endmodule

// ### tb/tb_nio_expander.sv
`timescale 1ns/1ps
module tb_nio_expander;
  logic       sys_clk_i = 1'b0;
  logic       rst_i     = 1'b1;
  logic       stb, csn;
  logic [3:0] hn, hp, ho, hoe, rd;
  logic [3:0] pin [4] = '{default: 4'h0};
  logic [3:0] po  [4];
  logic [3:0] poe [4];
  int         err_total   = 0;
  int         checks_done = 0;
  // Clock and host pin resolution
  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  assign hp = hoe[0] ? ho : hn;
  nio_host u_host (.sys_clk_i(sys_clk_i), .pin_i(hp), .strobe_o(stb),
    .cs_n_o(csn), .nib_o(hn));
  nio_expander u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .program_strobe_i(stb), .chip_select_n_i(csn),
    .host_nibble_port_i(hp), .host_nibble_port_o(ho),
    .host_nibble_port_oe_o(hoe),
    .peripheral_port_a_i(pin[0]), .peripheral_port_a_o(po[0]),
    .peripheral_port_a_oe_o(poe[0]),
    .peripheral_port_b_i(pin[1]), .peripheral_port_b_o(po[1]),
    .peripheral_port_b_oe_o(poe[1]),
    .peripheral_port_c_i(pin[2]), .peripheral_port_c_o(po[2]),
    .peripheral_port_c_oe_o(poe[2]),
    .peripheral_port_d_i(pin[3]), .peripheral_port_d_o(po[3]),
    .peripheral_port_d_oe_o(poe[3]));
  // Compare and close
  task automatic chk(input string nm, input logic [3:0] e,
                     input logic [3:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Direct, OR and AND writes on every port
  task automatic t_write;
    for (int p = 0; p < 4; p++) begin
      u_host.xfer({2'h1, p[1:0]}, 4'h5, 1'b0, rd);
      chk("latch", 4'h5, po[p]);
      chk("port oe", 4'hF, poe[p]);
      u_host.xfer({2'h2, p[1:0]}, 4'hA, 1'b0, rd);
      chk("or", 4'hF, po[p]);
      u_host.xfer({2'h3, p[1:0]}, 4'h6, 1'b0, rd);
      chk("and", 4'h6, po[p]);
    end
  endtask
  // Reads return port input and leave it tri-stated
  task automatic t_read;
    for (int p = 0; p < 4; p++) begin
      pin[p] = 4'h9 ^ p[3:0];
      u_host.xfer({2'h0, p[1:0]}, 4'h0, 1'b0, rd);
      chk("read", 4'h9 ^ p[3:0], rd);
      chk("port oe", 4'h0, poe[p]);
      chk("host oe", 4'h0, hoe);
    end
  endtask
  // Deselected write ignored, then a real one drives again
  task automatic t_desel;
    u_host.xfer(4'h4, 4'h3, 1'b1, rd);
    chk("desel latch", 4'h6, po[0]);
    chk("desel oe", 4'h0, poe[0]);
    u_host.xfer(4'h4, 4'hC, 1'b0, rd);
    chk("rewrite", 4'hC, po[0]);
    chk("rewrite oe", 4'hF, poe[0]);
  endtask
  // Watchdog
  initial begin
    #2000000;
    err_total++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    t_write();
    t_read();
    t_desel();
    end_sim();
  end
endmodule
